/* File: core/restart_pkg.sv */
// How it works
// - Only the listed restartable fault kinds may lead to an automatic restart.
// - Bus undervoltage is restartable only with ride-through selection 1 through 4.
// - After the run command is withdrawn, a self-check precedes any restart.
// - A passed check with the cause gone starts speed search, then normal running.
// - Limit is 0 to 10 (restart_limit_in is not clamped, so 11 to 15 are also taken); at the limit the sequencer stops until manual reset.
// - Ten minutes of normal running after a restart clears the restart counter.
// - A manual fault clear sets the restart counter to zero.
// - A power cycle (reset) sets the restart counter to zero.
// - Fault output shows during restart only when the fault output selection is 1.
// - The restart-in-progress flag shows while restarting if output function is 1E.
// - Count mode 0 retries continuously and counts only successful restarts.
// - Count mode 1 spaces attempts by the interval and counts every attempt.
// - The restart interval is 0.5 to 600.0 s in 0.1 s steps, default 10.0 s.
package restart_pkg;
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned TICK_TIME_MS     = 100;
    localparam int unsigned TICK_CYCLES      = TICK_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int unsigned NORMAL_RUN_S     = 600;
    localparam int unsigned TICK_W           = 13;
    localparam int unsigned DIV_W            = 21;
    localparam logic [12:0] NORMAL_RUN_TICKS = 13'(NORMAL_RUN_S * 1000 / TICK_TIME_MS);
    localparam logic [12:0] INTERVAL_DEFAULT = 13'h0064;
    localparam logic [12:0] INTERVAL_MIN     = 13'h0005;
    localparam logic [12:0] INTERVAL_MAX     = 13'h1770;
    localparam logic [3:0]  LIMIT_DEFAULT    = 4'h0;
    localparam logic [3:0]  LIMIT_MAX        = 4'hA;
    localparam logic [3:0]  COUNT_RESET      = 4'h0;
    localparam logic [7:0]  FUNC_RESTARTING  = 8'h1E;
    localparam logic [2:0]  RIDE_SEL_LOW     = 3'h1;
    localparam logic [2:0]  RIDE_SEL_HIGH    = 3'h4;

    typedef enum logic [3:0] {
        ground_fault, output_phase_open_fault, overcurrent_fault, drive_overheat_fault,
        motor_overload_fault, drive_overload_fault, overtorque_one_fault, overtorque_two_fault,
        bus_overvoltage_fault, input_phase_loss_fault, brake_resistor_fault,
        brake_transistor_fault, bus_undervoltage_fault, pull_out_fault, other_fault
    } fault_code_t;

    typedef enum logic [2:0] {
        ST_RUN, ST_TRIPPED, ST_INTERVAL, ST_CHECK, ST_SEARCH, ST_LOCKOUT
    } seq_state_t;
endpackage

/* File: core/restart_timer_if.sv */
`timescale 1ns/10ps
interface restart_timer_if;
    logic        start;
    logic        abort;
    logic [12:0] load;
    logic        done;
    logic        busy;
    modport ctrl  (output start, output abort, output load, input done, input busy);
    modport timer (input start, input abort, input load, output done, output busy);
endinterface

/* File: core/restart_timer.sv */
`timescale 1ns/10ps
module restart_timer #(
    parameter int unsigned TICK_CYCLES = restart_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic      sys_clk_in,
    input  wire logic      rst_in,
    // Control from the sequencer.
    restart_timer_if.timer tmr
);
    import restart_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0]  div;
        logic [TICK_W-1:0] ticks;
        logic              busy;
        logic              done;
    } tmr_state_t;

    tmr_state_t r;
    tmr_state_t n;

    // Counts 0.1 s ticks down from the loaded value and pulses done once.
    always_comb begin
        n = r;
        n.done = 1'b0;
        if (tmr.abort) begin
            n.busy = 1'b0;
        end else if (tmr.start) begin
            n.busy  = 1'b1;
            n.div   = '0;
            n.ticks = (tmr.load == '0) ? 13'h0001 : tmr.load;
        end else if (r.busy) begin
            if (r.div == DIV_W'(TICK_CYCLES - 1)) begin
                n.div = '0;
                if (r.ticks == 13'h0001) begin
                    n.busy = 1'b0;
                    n.done = 1'b1;
                end else begin
                    n.ticks = r.ticks - 13'h0001;
                end
            end else begin
                n.div = r.div + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tmr.done = r.done;
    assign tmr.busy = r.busy;
endmodule

/* File: core/fault_auto_restart_sequencer.sv */
`timescale 1ns/10ps
module fault_auto_restart_sequencer #(
    parameter int unsigned TICK_CYCLES = restart_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_in,
    // Configuration.
    input  wire logic [3:0]               restart_limit_in,
    input  wire logic                     restart_fault_output_sel_in,
    input  wire logic [12:0]              restart_interval_time_in,
    input  wire logic                     restart_count_mode_in,
    input  wire logic [2:0]               power_loss_ride_through_sel_in,
    input  wire logic [7:0]               digital_output_1_function_in,
    // Drive events.
    input  wire logic                     fault_valid_in,
    input  wire restart_pkg::fault_code_t fault_code_in,
    input  wire logic                     run_cmd_in,
    input  wire logic                     self_check_pass_in,
    input  wire logic                     fault_cause_clear_in,
    input  wire logic                     speed_search_done_in,
    input  wire logic                     manual_reset_in,
    // Status outputs.
    output logic                          drive_enable_out,
    output logic                          speed_search_out,
    output logic                          fault_out,
    output logic                          restart_active_out,
    output logic                          lockout_out,
    output logic [3:0]                    restart_count_out
);
    import restart_pkg::*;

    typedef struct packed {
        seq_state_t state;
        logic [3:0] count;
        logic [2:0] run_sync;
        logic       run_flt;
        logic       tmr_start;
        logic       tmr_abort;
        logic [12:0] tmr_load;
        logic       enable_o;
        logic       search_o;
        logic       fault_o;
        logic       active_o;
        logic       lock_o;
    } seq_t;

    seq_t r;
    seq_t n;
    restart_timer_if tmr ();

    function automatic logic restartable(fault_code_t code, logic [2:0] ride_sel);
        logic ok;
        ok = 1'b1;
        if (code == other_fault) begin
            ok = 1'b0;
        end else if (code == bus_undervoltage_fault) begin
            ok = (ride_sel >= RIDE_SEL_LOW) && (ride_sel <= RIDE_SEL_HIGH);
        end
        return ok;
    endfunction

    function automatic logic [12:0] clamp_interval(logic [12:0] t);
        logic [12:0] v;
        v = t;
        if (t < INTERVAL_MIN) begin
            v = INTERVAL_MIN;
        end else if (t > INTERVAL_MAX) begin
            v = INTERVAL_MAX;
        end
        return v;
    endfunction

    function automatic logic restarting(seq_state_t s);
        return (s == ST_TRIPPED) || (s == ST_INTERVAL) || (s == ST_CHECK) || (s == ST_SEARCH);
    endfunction

    logic can_restart;
    logic at_limit;
    logic check_ok;
    logic [12:0] interval_ticks;

    assign interval_ticks = clamp_interval(restart_interval_time_in);
    assign can_restart = restartable(fault_code_in, power_loss_ride_through_sel_in);
    assign at_limit    = (r.count >= restart_limit_in);
    assign check_ok    = self_check_pass_in && fault_cause_clear_in;

    always_comb begin
        n = r;
        n.tmr_start = 1'b0;
        n.tmr_abort = 1'b0;
        n.run_sync  = {r.run_sync[1:0], run_cmd_in};
        if (r.run_sync[1] == r.run_sync[2]) begin
            n.run_flt = r.run_sync[2];
        end
        case (r.state)
            ST_RUN: begin
                if (fault_valid_in) begin
                    n.tmr_abort = 1'b1;
                    if (!can_restart || restart_limit_in == 4'h0) begin
                        n.state = ST_LOCKOUT;
                    end else if (!restart_count_mode_in && at_limit) begin
                        n.state = ST_LOCKOUT;
                    end else begin
                        n.state = ST_TRIPPED;
                    end
                end else if (tmr.done) begin
                    n.count = COUNT_RESET;
                end
            end
            ST_TRIPPED: begin
                if (!r.run_flt) begin
                    if (restart_count_mode_in) begin
                        n.state     = ST_INTERVAL;
                        n.tmr_start = 1'b1;
                        n.tmr_load  = interval_ticks;
                    end else begin
                        n.state = ST_CHECK;
                    end
                end
            end
            ST_INTERVAL: begin
                if (tmr.done) begin
                    n.state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (restart_count_mode_in) begin
                    if (at_limit) begin
                        n.state = ST_LOCKOUT;
                    end else begin
                        n.count = r.count + 4'h1;
                        if (check_ok) begin
                            n.state = ST_SEARCH;
                        end else begin
                            n.state     = ST_INTERVAL;
                            n.tmr_start = 1'b1;
                            n.tmr_load  = interval_ticks;
                        end
                    end
                end else if (check_ok) begin
                    n.state = ST_SEARCH;
                end
            end
            ST_SEARCH: begin
                if (fault_valid_in) begin
                    n.state = can_restart ? ST_TRIPPED : ST_LOCKOUT;
                end else if (speed_search_done_in) begin
                    n.state     = ST_RUN;
                    n.tmr_start = 1'b1;
                    n.tmr_load  = NORMAL_RUN_TICKS;
                    if (!restart_count_mode_in) begin
                        n.count = r.count + 4'h1;
                    end
                end
            end
            default: begin
                n.state = ST_LOCKOUT;
            end
        endcase
        if (manual_reset_in) begin
            n.count     = COUNT_RESET;
            n.tmr_abort = 1'b1;
            n.tmr_start = 1'b0;
            if (r.state != ST_RUN) begin
                n.state = ST_RUN;
            end
        end
        n.enable_o = (n.state == ST_RUN) || (n.state == ST_SEARCH);
        n.search_o = (n.state == ST_SEARCH);
        n.lock_o   = (n.state == ST_LOCKOUT);
        n.fault_o  = n.lock_o || (restarting(n.state) && restart_fault_output_sel_in);
        n.active_o = restarting(n.state) && (digital_output_1_function_in == FUNC_RESTARTING);
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r          <= '0;
            r.state    <= ST_RUN;
            r.count    <= COUNT_RESET;
            r.tmr_load <= INTERVAL_DEFAULT;
        end else begin
            r <= n;
        end
    end

    assign tmr.start = r.tmr_start;
    assign tmr.abort = r.tmr_abort;
    assign tmr.load  = r.tmr_load;

    restart_timer #(.TICK_CYCLES(TICK_CYCLES)) restart_timer_i (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .tmr        (tmr.timer)
    );

    assign drive_enable_out   = r.enable_o;
    assign speed_search_out   = r.search_o;
    assign fault_out          = r.fault_o;
    assign restart_active_out = r.active_o;
    assign lockout_out        = r.lock_o;
    assign restart_count_out  = r.count;

    a_nonrestart_lockout: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (r.state == ST_RUN && fault_valid_in && !manual_reset_in && fault_code_in == other_fault)
        |=> ##1 lockout_out)
        else $error("Non-restartable fault did not lock out.");
    a_undervolt_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (r.state == ST_RUN && fault_valid_in && !manual_reset_in
         && fault_code_in == bus_undervoltage_fault && power_loss_ride_through_sel_in == 3'h0)
        |=> r.state == ST_LOCKOUT)
        else $error("Undervoltage restarted without ride-through.");
    a_check_after_run: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (r.state == ST_SEARCH) |-> $past(r.state) inside {ST_CHECK, ST_SEARCH})
        else $error("Speed search entered without self-check.");
    a_search_on_pass: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (r.state == ST_CHECK && !restart_count_mode_in && check_ok && !manual_reset_in)
        |=> r.state == ST_SEARCH ##1 speed_search_out)
        else $error("Passed self-check did not start speed search.");
    a_zero_limit_stop: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (r.state == ST_RUN && fault_valid_in && !manual_reset_in && restart_limit_in == 4'h0)
        |=> r.state == ST_LOCKOUT)
        else $error("Zero limit still allowed a restart.");
    a_manual_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        manual_reset_in |=> restart_count_out == 4'h0 && !lockout_out)
        else $error("Manual reset did not clear counter.");
    a_count_success: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (r.state == ST_SEARCH && !restart_count_mode_in && speed_search_done_in
         && !fault_valid_in && !manual_reset_in)
        |=> restart_count_out == $past(restart_count_out) + 4'h1)
        else $error("Successful restart not counted.");
    a_attempt_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (r.state == ST_CHECK && restart_count_mode_in && !at_limit && !manual_reset_in)
        |=> restart_count_out == $past(restart_count_out) + 4'h1)
        else $error("Restart attempt not counted.");
    a_fault_quiet: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (restarting(r.state) && !$past(restart_fault_output_sel_in)) |-> !fault_out)
        else $error("Fault output shown during restart with selection 0.");
    a_active_flag: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        restart_active_out |-> restarting(r.state) && $past(digital_output_1_function_in) == FUNC_RESTARTING)
        else $error("Restart flag without restart or function code.");
endmodule

/* File: tb/run_sequencer_model.sv */
`timescale 1ns/10ps
module run_sequencer_model (
    // Clock and reset.
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    // Drive status.
    input  wire logic       drive_enable_in,
    input  wire logic       speed_search_in,
    input  wire logic [7:0] hold_cycles_in,
    // Commands to the drive.
    output logic            run_cmd_out,
    output logic            speed_search_done_out
);
    logic [7:0] hold_r;
    logic [1:0] search_r;

    assign speed_search_done_out = speed_search_in && (search_r == 2'h3);

    // Withdraws the run command a set time after the drive shuts off.
    always @(negedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_r <= 8'h00;
            run_cmd_out <= 1'b0;
        end else if (drive_enable_in) begin
            hold_r <= 8'h00;
            run_cmd_out <= 1'b1;
        end else if (hold_r >= hold_cycles_in) begin
            run_cmd_out <= 1'b0;
        end else begin
            hold_r <= hold_r + 8'h01;
        end
    end

    // Reports speed search finished after three cycles of searching.
    always @(negedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            search_r <= 2'h0;
        end else if (!speed_search_in) begin
            search_r <= 2'h0;
        end else if (search_r != 2'h3) begin
            search_r <= search_r + 2'h1;
        end
    end
endmodule

/* File: tb/fault_auto_restart_sequencer_tb.sv */
`timescale 1ns/10ps
module fault_auto_restart_sequencer_tb;
    import restart_pkg::*;
    localparam int TCK     = 4;
    localparam int CEILING = 40000;
    logic        sys_clk_in;
    logic        rst_in;
    logic [3:0]  limit;
    logic        fo_sel;
    logic [12:0] interval;
    logic        mode;
    logic [2:0]  ride_sel;
    logic [7:0]  func;
    logic        fault_valid;
    fault_code_t code;
    logic        run_cmd;
    logic        check_ok;
    logic        cause_clr;
    logic        ss_done;
    logic        manual_reset;
    logic [7:0]  hold;
    logic        drive_enable_out;
    logic        speed_search_out;
    logic        fault_out;
    logic        restart_active_out;
    logic        lockout_out;
    logic [3:0]  restart_count_out;
    logic [2:0]  rides [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    fault_auto_restart_sequencer #(.TICK_CYCLES(TCK)) fault_auto_restart_sequencer_i (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .restart_limit_in(limit),
        .restart_fault_output_sel_in(fo_sel), .restart_interval_time_in(interval),
        .restart_count_mode_in(mode), .power_loss_ride_through_sel_in(ride_sel),
        .digital_output_1_function_in(func), .fault_valid_in(fault_valid), .fault_code_in(code),
        .run_cmd_in(run_cmd), .self_check_pass_in(check_ok), .fault_cause_clear_in(cause_clr),
        .speed_search_done_in(ss_done), .manual_reset_in(manual_reset),
        .drive_enable_out(drive_enable_out), .speed_search_out(speed_search_out), .fault_out(fault_out),
        .restart_active_out(restart_active_out), .lockout_out(lockout_out),
        .restart_count_out(restart_count_out));

    run_sequencer_model run_sequencer_model_i (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .drive_enable_in(drive_enable_out),
        .speed_search_in(speed_search_out), .hold_cycles_in(hold), .run_cmd_out(run_cmd),
        .speed_search_done_out(ss_done));

    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    task finish_test;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc >= CEILING) begin
            n_mismatch++;
            finish_test();
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task cyc_n(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask

    function logic pick(input int k);
        case (k)
            0: return speed_search_out;
            1: return lockout_out;
            default: return restart_count_out == 4'h0;
        endcase
    endfunction

    task wait_for(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(k) !== v && n < lim) begin
            @(negedge sys_clk_in);
            n++;
        end
        check(8'(pick(k)), 8'(v));
    endtask

    task fault(input fault_code_t c);
        @(negedge sys_clk_in);
        fault_valid = 1'b1;
        code = c;
        @(negedge sys_clk_in);
        fault_valid = 1'b0;
        cyc_n(2);
    endtask

    task manual;
        @(negedge sys_clk_in);
        manual_reset = 1'b1;
        @(negedge sys_clk_in);
        manual_reset = 1'b0;
        cyc_n(5);
    endtask

    task restart(input fault_code_t c, input logic exp_fo, input logic exp_ra);
        fault(c);
        check(8'(restart_active_out), 8'(exp_ra));
        check(8'(fault_out), 8'(exp_fo));
        check(8'(drive_enable_out), 8'h00);
        wait_for(0, 1'b1, 300);
        wait_for(0, 1'b0, 50);
        cyc_n(5);
        check(8'(drive_enable_out), 8'h01);
    endtask

    initial begin
        rst_in = 1'b1;
        limit = 4'h2;
        fo_sel = 1'b0;
        interval = 13'h0005;
        mode = 1'b0;
        ride_sel = 3'h0;
        func = FUNC_RESTARTING;
        fault_valid = 1'b0;
        code = ground_fault;
        check_ok = 1'b1;
        cause_clr = 1'b1;
        manual_reset = 1'b0;
        hold = 8'h03;
        cyc_n(20);
        check(8'(drive_enable_out), 8'h00);
        rst_in = 1'b0;
        cyc_n(5);
        check(8'(drive_enable_out), 8'h01);
        for (int i = 0; i < 14; i++) begin
            if (fault_code_t'(i) != bus_undervoltage_fault) begin
                manual();
                restart(fault_code_t'(i), 1'b0, 1'b1);
                check(8'(restart_count_out), 8'h01);
            end
        end
        manual();
        restart(overcurrent_fault, 1'b0, 1'b1);
        restart(overcurrent_fault, 1'b0, 1'b1);
        check(8'(restart_count_out), 8'h02);
        fault(overcurrent_fault);
        cyc_n(10);
        check(8'(lockout_out), 8'h01);
        check(8'(fault_out), 8'h01);
        check(8'(restart_count_out), 8'h02);
        manual();
        check(8'(restart_count_out), 8'h00);
        check(8'(lockout_out), 8'h00);
        for (int i = 0; i < 4; i++) begin
            ride_sel = rides[i];
            manual();
            fault(bus_undervoltage_fault);
            check(8'(restart_active_out), 8'(ride_sel >= 3'h1 && ride_sel <= 3'h4));
            check(8'(lockout_out), 8'(ride_sel == 3'h0 || ride_sel == 3'h5));
        end
        manual();
        fault(other_fault);
        check(8'(lockout_out), 8'h01);
        manual();
        cause_clr = 1'b0;
        fault(overcurrent_fault);
        cyc_n(30);
        check(8'(speed_search_out), 8'h00);
        check(8'(restart_active_out), 8'h01);
        cause_clr = 1'b1;
        wait_for(0, 1'b1, 300);
        fault(other_fault);
        check(8'(lockout_out), 8'h01);
        check(8'(restart_count_out), 8'h00);
        manual();
        fo_sel = 1'b1;
        func = 8'h1F;
        hold = 8'h1E;
        fault(overcurrent_fault);
        check(8'(fault_out), 8'h01);
        check(8'(restart_active_out), 8'h00);
        cyc_n(20);
        check(8'(speed_search_out), 8'h00);
        wait_for(0, 1'b1, 300);
        wait_for(0, 1'b0, 50);
        fo_sel = 1'b0;
        func = FUNC_RESTARTING;
        hold = 8'h03;
        manual();
        limit = 4'h0;
        fault(ground_fault);
        check(8'(lockout_out), 8'h01);
        manual();
        limit = 4'h2;
        mode = 1'b1;
        check_ok = 1'b0;
        fault(overcurrent_fault);
        cyc_n(10);
        check(8'(restart_count_out), 8'h00);
        cyc_n(25);
        check(8'(restart_count_out), 8'h01);
        wait_for(1, 1'b1, 400);
        check(8'(restart_count_out), 8'h02);
        check_ok = 1'b1;
        manual();
        restart(overcurrent_fault, 1'b0, 1'b1);
        check(8'(restart_count_out), 8'h01);
        mode = 1'b0;
        manual();
        restart(overcurrent_fault, 1'b0, 1'b1);
        cyc_n(6000 * TCK - 100);
        check(8'(restart_count_out), 8'h01);
        wait_for(2, 1'b1, 300);
        restart(overcurrent_fault, 1'b0, 1'b1);
        rst_in = 1'b1;
        cyc_n(2);
        check(8'(restart_count_out), 8'h00);
        rst_in = 1'b0;
        cyc_n(5);
        check(8'(drive_enable_out), 8'h01);
        finish_test();
    end
endmodule
